//--- logic/pulse_count_pkg.sv
// Constants, types and register map of the pulse count accumulator
//
// Overview of operation
// - High-frequency mode counts a rise from below low threshold to above high threshold.
// - High-frequency mode sees pulses of 2 us, up to 250 kHz when chained.
// - Switch reopening for up to 1 ms is bounce and adds no count.
// - Two channels, each with its own 8-bit counter.
// - 16-bit mode chains both counters on channel 1; channel 2 idles.
// - Every 0.125 s counters add into 16-bit accumulators and clear.
// - An 8-bit counter holds at most 255 counts per transfer interval.
// - Table start copies each accumulator into its buffer, then zeroes it.
// - Operation writes buffer times multiplier plus offset to the result.
// - Buffer is overwritten on every table start unless discarded, never accumulated.
// - With discard, a long interval keeps the previous buffer value.
// - Frequency option divides count by interval seconds and also discards.
// - Code 0 HF, 1 AC, 2 switch, 3 HF 16-bit, 4 AC 16-bit.
package pulse_count_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ      = 40_000_000;
  localparam int unsigned TRANSFER_MS = 125;
  localparam int unsigned TRANSFER_CYC = CLK_HZ / 1000 * TRANSFER_MS;
  localparam int unsigned BOUNCE_US   = 1000;
  localparam int unsigned BOUNCE_CYC  = CLK_HZ / 1_000_000 * BOUNCE_US;
  localparam int unsigned TICKS_PER_S = 1000 / TRANSFER_MS;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] CFG0_OFF = 8'h00;
  localparam logic [7:0] CFG1_OFF = 8'h04;
  localparam logic [7:0] INTV_OFF = 8'h08;
  localparam logic [7:0] MULT_OFF = 8'h0c;
  localparam logic [7:0] OFFS_OFF = 8'h10;
  localparam logic [7:0] CMD_OFF  = 8'h14;
  localparam logic [7:0] STAT_OFF = 8'h18;
  localparam logic [7:0] ACC0_OFF = 8'h1c;
  localparam logic [7:0] BUF0_OFF = 8'h24;
  localparam logic [7:0] RES0_OFF = 8'h2c;
  // ==========================================================
  // Field positions and reset values
  localparam int unsigned CFG_TYPE_LSB = 0;
  localparam int unsigned CFG_OPT_LSB  = 4;
  localparam int unsigned CMD_START    = 0;
  localparam int unsigned CMD_EXEC     = 1;
  localparam int unsigned CMD_TRESET   = 2;
  localparam logic [15:0] INTV_RST = 16'h0008;
  localparam logic [15:0] MULT_RST = 16'h0001;
  localparam logic [7:0]  CNT_MAX  = 8'hff;
  localparam logic [15:0] ACC_MAX  = 16'hffff;
  localparam int unsigned DIV_BITS = 20;
  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    IN_HF = 3'h0, IN_AC = 3'h1, IN_SW = 3'h2, IN_HF16 = 3'h3, IN_AC16 = 3'h4
  } in_type_t;
  typedef enum logic [1:0] {OPT_KEEP = 2'h0, OPT_DISCARD = 2'h1, OPT_FREQ = 2'h2} opt_t;
  typedef struct packed {
    logic hi_above;  // Input above high threshold
    logic lo_below;  // Input below low threshold
    logic ac_level;  // Low-level AC comparator output
    logic sw_closed; // Switch contact closed
  } pulse_pins_t;
  typedef struct packed {
    in_type_t itype;
    opt_t     opt;
  } chan_cfg_t;
endpackage : pulse_count_pkg

//--- logic/pulse_count_accumulator.sv
// Pulse counting front end with accumulators, snapshot buffers and scaling
`timescale 1ns/10ps
`default_nettype none
module pulse_count_accumulator #(
  parameter int unsigned TRANSFER_CYC = pulse_count_pkg::TRANSFER_CYC,
  parameter int unsigned BOUNCE_CYC   = pulse_count_pkg::BOUNCE_CYC
) (
  input  wire logic                                clk_i,
  input  wire logic                                resetn_i,
  input  wire logic [7:0]                          paddr_i,
  input  wire logic                                psel_i,
  input  wire logic                                penable_i,
  input  wire logic                                pwrite_i,
  input  wire logic [31:0]                         pwdata_i,
  output logic      [31:0]                         prdata_o,
  output logic                                     pready_o,
  output logic                                     pslverr_o,
  input  wire pulse_count_pkg::pulse_pins_t [1:0]  pins_i
);
  import pulse_count_pkg::*;

  // ==========================================================
  // Register bus
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d, pslverr_q, pslverr_d;
  chan_cfg_t [1:0] cfg_q, cfg_d;
  logic [15:0] intv_q, intv_d, mult_q, mult_d;
  logic [31:0] offs_q, offs_d;
  logic        wr_en, start_cmd, exec_cmd, treset_cmd;
  logic [15:0] acc_q [2];
  logic [15:0] buf_q [2];
  logic [31:0] res_q [2];
  logic        busy, long_q;

  function automatic logic mapped(input logic [7:0] a);
    return a[1:0] == 2'h0 && a <= RES0_OFF + 8'h04;
  endfunction : mapped

  function automatic logic is16(input chan_cfg_t c);
    return c.itype == IN_HF16 || c.itype == IN_AC16;
  endfunction : is16

  assign wr_en      = psel_i & penable_i & pready_q & pwrite_i & mapped(paddr_i);
  assign start_cmd  = wr_en & (paddr_i == CMD_OFF) & pwdata_i[CMD_START];
  assign exec_cmd   = wr_en & (paddr_i == CMD_OFF) & pwdata_i[CMD_EXEC];
  assign treset_cmd = wr_en & (paddr_i == CMD_OFF) & pwdata_i[CMD_TRESET];

  // Zero-wait slave: answer is prepared in the setup cycle
  always_comb begin
    pready_d  = psel_i & ~penable_i;
    pslverr_d = psel_i & ~penable_i & ~mapped(paddr_i);
    prdata_d  = prdata_q;
    cfg_d     = cfg_q;
    intv_d    = intv_q;
    mult_d    = mult_q;
    offs_d    = offs_q;
    if (psel_i & ~penable_i) begin
      case (paddr_i)
        // Read back in the same field places that a write uses
        CFG0_OFF: prdata_d = {24'h0, 2'h0, cfg_q[0].opt, 1'b0, cfg_q[0].itype};
        CFG1_OFF: prdata_d = {24'h0, 2'h0, cfg_q[1].opt, 1'b0, cfg_q[1].itype};
        INTV_OFF: prdata_d = {16'h0, intv_q};
        MULT_OFF: prdata_d = {16'h0, mult_q};
        OFFS_OFF: prdata_d = offs_q;
        STAT_OFF: prdata_d = {30'h0, long_q, busy};
        ACC0_OFF: prdata_d = {16'h0, acc_q[0]};
        ACC0_OFF + 8'h04: prdata_d = {16'h0, acc_q[1]};
        BUF0_OFF: prdata_d = {16'h0, buf_q[0]};
        BUF0_OFF + 8'h04: prdata_d = {16'h0, buf_q[1]};
        RES0_OFF: prdata_d = res_q[0];
        RES0_OFF + 8'h04: prdata_d = res_q[1];
        default:  prdata_d = 32'h0;
      endcase
    end
    if (wr_en) begin
      case (paddr_i)
        CFG0_OFF: cfg_d[0] = {pwdata_i[CFG_TYPE_LSB +: 3], pwdata_i[CFG_OPT_LSB +: 2]};
        CFG1_OFF: cfg_d[1] = {pwdata_i[CFG_TYPE_LSB +: 3], pwdata_i[CFG_OPT_LSB +: 2]};
        INTV_OFF: intv_d = pwdata_i[15:0];
        MULT_OFF: mult_d = pwdata_i[15:0];
        OFFS_OFF: offs_d = pwdata_i;
        default:  ;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prdata_q <= 32'h0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      cfg_q    <= '0;
      intv_q   <= INTV_RST;
      mult_q   <= MULT_RST;
      offs_q   <= 32'h0;
    end else begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      cfg_q    <= cfg_d;
      intv_q   <= intv_d;
      mult_q   <= mult_d;
      offs_q   <= offs_d;
    end
  end

  assign prdata_o  = prdata_q;
  assign pready_o  = pready_q;
  assign pslverr_o = pslverr_q;

  // ==========================================================
  // Transfer tick divider
  logic [22:0] tdiv_q, tdiv_d;
  logic        tick;
  assign tick = tdiv_q == 23'(TRANSFER_CYC - 1);
  always_comb begin
    tdiv_d = tick ? 23'h0 : tdiv_q + 23'h1;
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) tdiv_q <= 23'h0;
    else tdiv_q <= tdiv_d;
  end

  // ==========================================================
  // Per-channel input front end; edges are sampled straight off the pins
  logic [1:0] hit;
  for (genvar c = 0; c < 2; c++) begin : g_front
    logic        arm_q, arm_d, ac_q, ac_d, swst_q, swst_d;
    logic [15:0] open_q, open_d;
    pulse_pins_t p;
    assign p = pins_i[c];
    always_comb begin
      arm_d  = arm_q;
      ac_d   = p.ac_level;
      swst_d = swst_q;
      open_d = 16'h0;
      hit[c] = 1'b0;
      case (cfg_q[c].itype)
        IN_HF, IN_HF16: begin
          // Arming below the low level gives the wide hysteresis band
          if (p.lo_below) arm_d = 1'b1;
          else if (arm_q && p.hi_above) begin
            arm_d  = 1'b0;
            hit[c] = 1'b1;
          end
        end
        IN_AC, IN_AC16: hit[c] = p.ac_level & ~ac_q;
        IN_SW: begin
          if (!swst_q) begin
            if (p.sw_closed) begin
              swst_d = 1'b1;
              hit[c] = 1'b1;
            end
          end else if (!p.sw_closed) begin
            // Short reopenings are bounce; only a long open re-arms
            open_d = open_q + 16'h1;
            if (open_q == 16'(BOUNCE_CYC - 1)) swst_d = 1'b0;
          end
        end
        default: ;
      endcase
    end
    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        arm_q  <= 1'b0;
        ac_q   <= 1'b0;
        swst_q <= 1'b0;
        open_q <= 16'h0;
      end else begin
        arm_q  <= arm_d;
        ac_q   <= ac_d;
        swst_q <= swst_d;
        open_q <= open_d;
      end
    end
    a_sw_bounce: assert property (@(posedge clk_i) disable iff (!resetn_i)
      cfg_q[c].itype == IN_SW && swst_q && open_q == 16'h0 ##0 (!p.sw_closed)[*8]
      |-> swst_q) else $error("switch released during bounce window");
  end

  // ==========================================================
  // Hardware counters, accumulators and snapshot buffers
  logic [7:0]  cnt_q [2];
  logic [7:0]  cnt_d [2];
  logic [15:0] acc_d [2];
  logic [15:0] buf_d [2];
  logic [15:0] elap_q, elap_d;
  logic        long_d, mode16, long_now;
  logic [15:0] chain, chain_inc, add [2];
  logic [16:0] sum [2];

  assign mode16    = is16(cfg_q[0]);
  assign chain     = {cnt_q[1], cnt_q[0]};
  assign chain_inc = (chain == ACC_MAX) ? chain : chain + 16'h1;
  assign long_now  = long_q | (elap_q > intv_q);

  always_comb begin
    elap_d = (elap_q == ACC_MAX || !tick) ? elap_q : elap_q + 16'h1;
    long_d = long_q | treset_cmd;
    for (int i = 0; i < 2; i++) begin
      cnt_d[i] = cnt_q[i];
      acc_d[i] = acc_q[i];
      buf_d[i] = buf_q[i];
      sum[i]   = 17'h0;
      add[i]   = 16'h0;
    end
    if (mode16) begin
      // Channel 2 input is ignored; its counter holds the upper byte
      {cnt_d[1], cnt_d[0]} = hit[0] ? chain_inc : chain;
      add[0] = chain;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (hit[i] && cnt_q[i] != CNT_MAX) cnt_d[i] = cnt_q[i] + 8'h1;
        add[i] = {8'h0, cnt_q[i]};
      end
    end
    if (tick) begin
      // A pulse in the transfer cycle lands in the fresh counter
      for (int i = 0; i < 2; i++) cnt_d[i] = 8'h0;
      if (mode16) cnt_d[0] = {7'h0, hit[0]};
      else for (int i = 0; i < 2; i++) cnt_d[i] = {7'h0, hit[i]};
    end
    for (int i = 0; i < 2; i++) begin
      sum[i] = {1'b0, start_cmd ? 16'h0 : acc_q[i]} + (tick ? {1'b0, add[i]} : 17'h0);
      acc_d[i] = sum[i][16] ? ACC_MAX : sum[i][15:0];
      if (start_cmd) begin
        // Discarding keeps the last good value for rate-type results
        if (!(cfg_q[i].opt != OPT_KEEP && long_now)) buf_d[i] = acc_q[i];
      end
    end
    if (start_cmd) begin
      elap_d = tick ? 16'h1 : 16'h0;
      long_d = treset_cmd;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < 2; i++) begin
        cnt_q[i] <= 8'h0;
        acc_q[i] <= 16'h0;
        buf_q[i] <= 16'h0;
      end
      elap_q <= 16'h0;
      long_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      acc_q  <= acc_d;
      buf_q  <= buf_d;
      elap_q <= elap_d;
      long_q <= long_d;
    end
  end

  // ==========================================================
  // Scaling engine: optional restoring divide, then multiply and offset
  typedef enum logic [1:0] {S_IDLE, S_DIV, S_STORE} eng_t;
  eng_t        st_q, st_d;
  logic        ch_q, ch_d;
  logic [4:0]  bit_q, bit_d;
  logic [19:0] quo_q, quo_d, rem_q, rem_d, trial;
  logic [31:0] res_d [2];
  logic [35:0] prod;

  assign busy  = st_q != S_IDLE;
  assign trial = {rem_q[18:0], quo_q[19]};
  assign prod  = 36'(quo_q) * 36'(mult_q);

  always_comb begin
    st_d  = st_q;
    ch_d  = ch_q;
    bit_d = bit_q;
    quo_d = quo_q;
    rem_d = rem_q;
    res_d = res_q;
    case (st_q)
      S_IDLE: if (exec_cmd) begin
        st_d = S_DIV;
        ch_d = 1'b0;
        bit_d = 5'h0;
        quo_d = {1'b0, buf_q[0], 3'h0};
        rem_d = 20'h0;
      end
      S_DIV: begin
        if (cfg_q[ch_q].opt != OPT_FREQ || intv_q == 16'h0) begin
          // Plain count, and a zero interval has no rate to report
          quo_d = {4'h0, buf_q[ch_q]};
          st_d  = S_STORE;
        end else begin
          rem_d = (trial >= {4'h0, intv_q}) ? trial - {4'h0, intv_q} : trial;
          quo_d = {quo_q[18:0], trial >= {4'h0, intv_q}};
          bit_d = bit_q + 5'h1;
          if (bit_q == 5'(DIV_BITS - 1)) st_d = S_STORE;
        end
      end
      S_STORE: begin
        res_d[ch_q] = prod[31:0] + offs_q;
        if (ch_q) st_d = S_IDLE;
        else begin
          st_d = S_DIV;
          ch_d = 1'b1;
          bit_d = 5'h0;
          quo_d = {1'b0, buf_q[1], 3'h0};
          rem_d = 20'h0;
        end
      end
      default: st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q  <= S_IDLE;
      ch_q  <= 1'b0;
      bit_q <= 5'h0;
      quo_q <= 20'h0;
      rem_q <= 20'h0;
      res_q <= '{default: 32'h0};
    end else begin
      st_q  <= st_d;
      ch_q  <= ch_d;
      bit_q <= bit_d;
      quo_q <= quo_d;
      rem_q <= rem_d;
      res_q <= res_d;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_snap_long;
    start_cmd && cfg_q[0].opt != OPT_KEEP && long_now;
  endsequence

  a_apb_ready: assert property (s_setup |=> pready_o && prdata_o == $past(prdata_d))
    else $error("setup not answered next cycle");
  a_tick_clear: assert property (tick && !mode16 |=> cnt_q[0] <= 8'h1 && cnt_q[1] <= 8'h1)
    else $error("counter not cleared at transfer");
  a_cnt_hold: assert property (!mode16 && cnt_q[0] == CNT_MAX && !tick && !$past(mode16)
    |=> cnt_q[0] == CNT_MAX) else $error("8-bit counter wrapped");
  a_acc_sat: assert property (acc_q[0] == ACC_MAX && !start_cmd |=> acc_q[0] == ACC_MAX)
    else $error("accumulator wrapped");
  a_acc_zero: assert property (start_cmd && !tick |=> acc_q[0] == 16'h0 && acc_q[1] == 16'h0)
    else $error("accumulator not zeroed at table start");
  a_buf_load: assert property (start_cmd && cfg_q[0].opt == OPT_KEEP |=> buf_q[0] == $past(acc_q[0]))
    else $error("buffer not loaded at table start");
  a_buf_discard: assert property (s_snap_long |=> $stable(buf_q[0]))
    else $error("long interval count not discarded");
  a_chan2_idle: assert property (mode16 && $past(mode16) && tick && !start_cmd |=> $stable(acc_q[1]))
    else $error("channel 2 accumulated in chained mode");
  a_long_flag: assert property (!start_cmd && elap_q > intv_q |=> long_q || long_now)
    else $error("long interval not flagged");
  a_scale_done: assert property (exec_cmd && !busy |-> ##[2:46] st_q == S_STORE)
    else $error("scaling did not finish");
endmodule : pulse_count_accumulator
`default_nettype wire

//--- test/pulse_sensor_model.sv
// Partner model: comparator and switch levels of two pulse sensors
`timescale 1ns/10ps
`default_nettype none
module pulse_sensor_model #(
  parameter int unsigned BOUNCE_CYC = 20
) (
  input  wire logic                               clk_i,
  output var  pulse_count_pkg::pulse_pins_t [1:0] pins_o
);
  import pulse_count_pkg::*;
  // ==========================================================
  // Level tables {hi_above, lo_below, ac_level, sw_closed}
  // HF dips from high to mid must not re-arm, so one count per pass
  localparam logic [3:0] LV [3][5] = '{'{4'h0, 4'h8, 4'h0, 4'h8, 4'h4},
    '{4'h6, 4'h6, 4'h4, 4'h4, 4'h4}, '{4'h5, 4'h4, 4'h5, 4'h4, 4'h4}};
  // Switch steps in half-bounce units: closed 6, bounce 1, closed 6, open 12
  localparam int SWF [5] = '{6, 1, 6, 6, 6};
  initial pins_o = {2{4'h4}};
  // Every pass ends at the idle level, so passes chain without a glitch
  task automatic burst(input int ch, input int kind, input int n, input int w);
    for (int k = 0; k < n; k++) begin
      for (int s = 0; s < 5; s++) begin
        pins_o[ch] <= LV[kind][s];
        repeat ((kind == 2) ? SWF[s] * BOUNCE_CYC / 2 : w) @(posedge clk_i);
      end
    end
  endtask : burst
endmodule : pulse_sensor_model
`default_nettype wire

//--- test/tb_pulse_count_accumulator.sv
// Self-checking bench of the pulse count accumulator
`timescale 1ns/10ps
`default_nettype none
module tb_pulse_count_accumulator;
  import pulse_count_pkg::*;
  localparam int unsigned TC = 200;
  localparam int unsigned BC = 20;
  logic              clk;
  logic              resetn;
  logic [7:0]        paddr;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  pulse_pins_t [1:0] pins;
  int                error_cnt = 0;
  int                cmp_count = 0;
  logic [7:0]        lfsr = 8'h5d;
  logic [31:0]       mult;
  logic [31:0]       offs;
  int                n0;
  int                n1;

  pulse_count_accumulator #(.TRANSFER_CYC(TC), .BOUNCE_CYC(BC)) i_pulse_count_accumulator (
    .clk_i(clk), .resetn_i(resetn), .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .pins_i(pins));
  pulse_sensor_model #(.BOUNCE_CYC(BC)) i_pulse_sensor_model (.clk_i(clk), .pins_o(pins));

  always #12.5 clk = ~clk;

  // ==========================================================
  // Helpers
  // Maximal-length 8-bit sequence, never stuck at zero
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction : rnd
  // Result expected from a buffered count
  function automatic logic [31:0] scaled(input int cnt, input logic [15:0] iv, input logic fr);
    logic [31:0] q;
    q = fr ? 32'(cnt) * 32'(TICKS_PER_S) / 32'(iv) : 32'(cnt);
    return q * mult + offs;
  endfunction : scaled
  // One APB transfer; an idle cycle follows so strobes never toggle twice at one edge
  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    psel    <= 1'b1;
    paddr   <= a;
    pwrite  <= wr_en;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // No cycle limit here: a missing answer is left to the watchdog
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic chk(input logic [7:0] a, input logic [31:0] exp, input logic experr = 1'b0);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    cmp_count++;
    if (r !== exp || e !== experr) begin
      error_cnt++;
      $display("mismatch t=%0t addr %h got %h/%b exp %h", $time, a, r, e, exp);
    end
  endtask : chk
  task automatic ticks(input int n);
    repeat (n * TC + 10) @(posedge clk);
  endtask : ticks
  // Scaling takes a variable time, so poll busy rather than count cycles
  task automatic exec();
    logic [31:0] r;
    logic        e;
    wr(CMD_OFF, 32'h2);
    do begin
      apb(1'b0, STAT_OFF, 32'h0, r, e);
    end while (r[0] !== 1'b0);
  endtask : exec
  task automatic wrap_up();
    $display("checks %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  // ==========================================================
  // Main sequence
  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    // Reset values, then an unmapped and an unaligned address
    for (int a = 0; a <= 'h30; a += 4) begin
      if (a != CMD_OFF && a != STAT_OFF) begin
        chk(8'(a), a == INTV_OFF ? 32'(INTV_RST) : a == MULT_OFF ? 32'(MULT_RST) : 32'h0);
      end
    end
    chk(8'h40, 32'h0, 1'b1);
    chk(8'h02, 32'h0, 1'b1);
    // HF on channel 1, AC on channel 2, counted apart
    wr(CFG1_OFF, 32'(IN_AC));
    n0 = rnd() % 20 + 1;
    n1 = rnd() % 20 + 1;
    i_pulse_sensor_model.burst(0, 0, n0, rnd() % 3 + 1);
    i_pulse_sensor_model.burst(1, 1, n1, 1);
    ticks(2);
    chk(ACC0_OFF, 32'(n0));
    chk(ACC0_OFF + 8'h4, 32'(n1));
    // Snapshot, scaling by random factors, then an empty snapshot
    mult = {24'h0, rnd()};
    offs = {rnd(), 16'h0, rnd()};
    wr(MULT_OFF, mult);
    wr(OFFS_OFF, offs);
    wr(CMD_OFF, 32'h1);
    chk(BUF0_OFF, 32'(n0));
    chk(BUF0_OFF + 8'h4, 32'(n1));
    chk(ACC0_OFF, 32'h0);
    exec();
    chk(RES0_OFF, scaled(n0, 16'h8, 1'b0));
    chk(RES0_OFF + 8'h4, scaled(n1, 16'h8, 1'b0));
    wr(CMD_OFF, 32'h1);
    chk(BUF0_OFF, 32'h0);
    // Switch closures, each with a short reopening
    wr(CFG1_OFF, 32'(IN_SW));
    chk(CFG1_OFF, 32'(IN_SW));
    i_pulse_sensor_model.burst(1, 2, 3, 0);
    ticks(2);
    chk(ACC0_OFF + 8'h4, 32'h3);
    // Chained counters take channel 1 only
    wr(CMD_OFF, 32'h1);
    wr(CFG1_OFF, 32'(IN_HF));
    wr(CFG0_OFF, 32'(IN_HF16));
    n0 = rnd() % 40 + 1;
    i_pulse_sensor_model.burst(0, 0, n0, 1);
    i_pulse_sensor_model.burst(1, 0, 5, 1);
    wr(CFG0_OFF, 32'(IN_AC16));
    i_pulse_sensor_model.burst(0, 1, 7, 1);
    ticks(2);
    chk(ACC0_OFF, 32'(n0 + 7));
    chk(ACC0_OFF + 8'h4, 32'h0);
    // Discard: a timely snapshot is taken, long ones keep the buffer
    wr(CFG0_OFF, 32'h10);
    wr(CMD_OFF, 32'h1);
    n0 = rnd() % 20 + 1;
    i_pulse_sensor_model.burst(0, 0, n0, 1);
    ticks(2);
    wr(CMD_OFF, 32'h1);
    chk(BUF0_OFF, 32'(n0));
    i_pulse_sensor_model.burst(0, 0, 3, 1);
    wr(CMD_OFF, 32'h4);
    chk(STAT_OFF, 32'h2);
    ticks(2);
    wr(CMD_OFF, 32'h1);
    chk(BUF0_OFF, 32'(n0));
    chk(ACC0_OFF, 32'h0);
    i_pulse_sensor_model.burst(0, 0, 3, 1);
    ticks(10);
    wr(CMD_OFF, 32'h1);
    chk(BUF0_OFF, 32'(n0));
    // Frequency output over a four-tick interval
    wr(CFG0_OFF, 32'h20);
    chk(CFG0_OFF, 32'h20);
    wr(INTV_OFF, 32'h4);
    wr(CMD_OFF, 32'h1);
    n0 = rnd() % 20 + 1;
    i_pulse_sensor_model.burst(0, 0, n0, 1);
    ticks(2);
    wr(CMD_OFF, 32'h1);
    exec();
    chk(RES0_OFF, scaled(n0, 16'h4, 1'b1));
    wrap_up();
  end

  // Watchdog: the sequence needs about 6000 cycles
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    $display("mismatch t=%0t watchdog expired", $time);
    wrap_up();
  end
endmodule : tb_pulse_count_accumulator
`default_nettype wire
